// *** dsa_channel.sv ***
// Behaviour
// - Short-address channel with repeat cleared runs sequential mode.
// - Repeat and end-interrupt enable both set select idle mode.
// - Sequential mode steps memory address by 1 or 2, up or down.
// - Memory address register holds a full 24-bit address.
// - I/O address is 16 bits, upper byte all ones, never stepped.
// - Direction 0: memory is source; direction 1: memory is destination.
// - 16-bit counter decrements per transfer; at zero enable clears, stop.
// - Count end with interrupt enable set raises an interrupt request.
// - Counter loaded with zero means 65,536 transfers.
// - Idle mode leaves the memory address unchanged.
// - Idle mode moves exactly one unit per request until count ends.
// - Activation from external, serial done and timer 0..2 requests.
// - External request is selectable only on channel B.
// - Single address operation only on channel B.
// - Repeat mode reloads address and count, continues, no interrupt.
// - Auto-request normal mode starts on setup, runs to count end.
// - Cycle steal releases the bus after every single transfer.
// - Burst holds the bus until all transfers finish.
// - Auto-request selects burst or cycle steal.
// - Full-address modes use two full 24-bit addresses.
// - Block mode moves one block per request, restores one address.
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
module dsa_channel
   import dsa_pkg::*;
#(
   parameter bit IS_CHAN_B = 1'b1
) (
   input  wire logic        i_sys_clk,   // System clock, 50 MHz
   input  wire logic        i_rstn,      // Synchronous reset, active low
   input  wire logic        i_hsel,      // AHB slave select
   input  wire logic [31:0] i_haddr,     // AHB address
   input  wire logic [1:0]  i_htrans,    // AHB transfer type
   input  wire logic        i_hwrite,    // AHB write
   input  wire logic [2:0]  i_hsize,     // AHB size, word only
   input  wire logic [31:0] i_hwdata,    // AHB write data
   input  wire logic        i_hready,    // AHB ready
   output logic             o_hreadyout, // AHB slave ready
   output logic             o_hresp,     // AHB response
   output logic [31:0]      o_hrdata,    // AHB read data
   input  wire logic [2:0]  i_tmr_req,   // Timer activation requests
   input  wire logic        i_txc_req,   // Serial transmit complete
   input  wire logic        i_rxc_req,   // Serial receive complete
   input  wire logic        i_ext_req,   // External request
   output dsa_xfer_type     o_xfer,      // Current transfer description
   output logic             o_xfer_req,  // Transfer request, held to done
   input  wire logic        i_xfer_done, // Transfer finished
   output logic             o_bus_req,   // Bus ownership request
   output logic             o_end_irq    // Transfer end interrupt pulse
);

   dsa_acc_type   acc;
   logic          rd_take;
   logic          trig;
   logic          hreadyout_w;
   logic          hresp_w;
   dsa_ctrl_type  ctrl_reg, ctrl_next, ctrl_wr;
   logic [23:0]   mar_reg, mar_next, mar_base_reg, mar_base_next;
   logic [23:0]   marb_reg, marb_next, marb_base_reg, marb_base_next;
   logic [15:0]   io_address_reg_reg, io_address_reg_next;
   logic [15:0]   tcnt_reg, tcnt_next;
   logic [15:0]   bcnt_reg, bcnt_next;
   logic          pend_reg, pend_next;
   logic          inblk_reg, inblk_next;
   dsa_state_type state_reg, state_next;
   dsa_xfer_type  xfer_reg, xfer_next;
   logic          xreq_reg, xreq_next;
   logic          breq_reg, breq_next;
   logic          irq_reg, irq_next;
   logic [31:0]   rdata_reg, rdata_next;
   logic          m_seq, m_idle, m_rpt, m_blk, is_auto, go, last, wrap, fin;
   logic [23:0]   io_full;

   dsa_ahb_regif u_regif (
      .i_sys_clk   (i_sys_clk),
      .i_rstn      (i_rstn),
      .i_hsel      (i_hsel),
      .i_haddr     (i_haddr),
      .i_htrans    (i_htrans),
      .i_hwrite    (i_hwrite),
      .i_hready    (i_hready),
      .o_hreadyout (hreadyout_w),
      .o_hresp     (hresp_w),
      .o_rd_take   (rd_take),
      .o_acc       (acc)
   );

   dsa_req_sel #(.IS_CHAN_B(IS_CHAN_B)) u_req (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_tmr_req (i_tmr_req),
      .i_txc_req (i_txc_req),
      .i_rxc_req (i_rxc_req),
      .i_ext_req (i_ext_req),
      .i_src     (ctrl_reg.src),
      .o_trig    (trig)
   );

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   always_comb begin
      m_seq   = ~ctrl_reg.fae & ~ctrl_reg.repeat_enable_bit;
      m_idle  = ~ctrl_reg.fae & ctrl_reg.repeat_enable_bit & ctrl_reg.transfer_end_irq_enable;
      m_rpt   = ~ctrl_reg.fae & ctrl_reg.repeat_enable_bit & ~ctrl_reg.transfer_end_irq_enable;
      m_blk   = ctrl_reg.fae & ctrl_reg.blke;
      is_auto = ctrl_reg.fae & ~ctrl_reg.blke & (ctrl_reg.src == SRC_AUTO);
      io_full = {DSA_IO_HIGH, io_address_reg_reg};
      last    = (tcnt_reg == DSA_CNT_ONE);
      wrap    = (tcnt_reg[7:0] == DSA_LOW_ONE);
      go      = ctrl_reg.channel_transfer_enable & (pend_reg | is_auto | inblk_reg);
   end

   // ----------------------------------------------------------------
   // Software write image of the control register
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_wr = dsa_ctrl_type'(i_hwdata[15:0]);
      ctrl_wr.single = i_hwdata[12] & IS_CHAN_B;
   end

   // ----------------------------------------------------------------
   // Channel state: registers, counters and transfer sequencing
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_next      = ctrl_reg;
      mar_next       = mar_reg;
      mar_base_next  = mar_base_reg;
      marb_next      = marb_reg;
      marb_base_next = marb_base_reg;
      io_address_reg_next      = io_address_reg_reg;
      tcnt_next      = tcnt_reg;
      bcnt_next      = bcnt_reg;
      pend_next      = pend_reg;
      inblk_next     = inblk_reg;
      state_next     = state_reg;
      xfer_next      = xfer_reg;
      xreq_next      = xreq_reg;
      breq_next      = breq_reg;
      irq_next       = 1'b0;
      fin            = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (go) begin
               if (ctrl_reg.fae) begin
                  xfer_next.src = mar_reg;
                  xfer_next.dst = marb_reg;
               end else if (ctrl_reg.dir) begin
                  xfer_next.src = io_full;
                  xfer_next.dst = mar_reg;
               end else begin
                  xfer_next.src = mar_reg;
                  xfer_next.dst = io_full;
               end
               xfer_next.word   = ctrl_reg.word;
               xfer_next.single = ctrl_reg.single;
               xreq_next        = 1'b1;
               breq_next        = 1'b1;
               if (!inblk_reg) begin
                  pend_next = 1'b0;
               end
               state_next = ST_XFER;
            end else begin
               breq_next = 1'b0;
            end
         end
         ST_XFER: begin
            if (i_xfer_done) begin
               xreq_next  = 1'b0;
               state_next = ST_IDLE;
               if (!m_idle) begin
                  mar_next = dsa_step(mar_reg, ctrl_reg.word, ctrl_reg.dec);
               end
               if (ctrl_reg.fae && !ctrl_reg.marb_fix) begin
                  marb_next = dsa_step(marb_reg, ctrl_reg.word, ctrl_reg.marb_dec);
               end
               if (m_rpt) begin
                  if (wrap) begin
                     tcnt_next[7:0] = tcnt_reg[15:8];
                     mar_next       = mar_base_reg;
                  end else begin
                     tcnt_next[7:0] = tcnt_reg[7:0] - DSA_LOW_ONE;
                  end
               end else if (m_blk) begin
                  if (wrap) begin
                     tcnt_next[7:0] = tcnt_reg[15:8];
                     inblk_next     = 1'b0;
                     bcnt_next      = bcnt_reg - DSA_CNT_ONE;
                     fin            = (bcnt_reg == DSA_CNT_ONE);
                     if (ctrl_reg.blk_dst) begin
                        marb_next = marb_base_reg;
                     end else begin
                        mar_next = mar_base_reg;
                     end
                  end else begin
                     tcnt_next[7:0] = tcnt_reg[7:0] - DSA_LOW_ONE;
                     inblk_next     = 1'b1;
                  end
               end else begin
                  tcnt_next = tcnt_reg - DSA_CNT_ONE;
                  fin       = last;
               end
               if (fin) begin
                  ctrl_next.channel_transfer_enable = 1'b0;
                  irq_next      = ctrl_reg.transfer_end_irq_enable;
                  inblk_next    = 1'b0;
               end
               breq_next = is_auto & ctrl_reg.burst & ~fin;
            end
         end
         default: begin
            state_next = ST_IDLE;
            xreq_next  = 1'b0;
            breq_next  = 1'b0;
         end
      endcase
      if (trig) begin
         pend_next = 1'b1;
      end
      if (acc.wr_en) begin
         case (acc.addr)
            DSA_OFF_CTRL: begin
               ctrl_next = ctrl_wr;
               if (!ctrl_wr.channel_transfer_enable) begin
                  inblk_next = 1'b0;
               end
            end
            DSA_OFF_MAR: begin
               mar_next      = i_hwdata[23:0];
               mar_base_next = i_hwdata[23:0];
            end
            DSA_OFF_MARB: begin
               marb_next      = i_hwdata[23:0];
               marb_base_next = i_hwdata[23:0];
            end
            DSA_OFF_IO_ADDRESS_REG: io_address_reg_next = i_hwdata[15:0];
            DSA_OFF_TCNT: tcnt_next = i_hwdata[15:0];
            DSA_OFF_BCNT: bcnt_next = i_hwdata[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data, captured in the address phase
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = rdata_reg;
      if (rd_take) begin
         case (i_haddr[7:0])
            DSA_OFF_CTRL: rdata_next = {16'h0000, ctrl_reg};
            DSA_OFF_MAR:  rdata_next = {8'h00, mar_reg};
            DSA_OFF_IO_ADDRESS_REG: rdata_next = {16'h0000, io_address_reg_reg};
            DSA_OFF_TCNT: rdata_next = {16'h0000, tcnt_reg};
            DSA_OFF_MARB: rdata_next = {8'h00, marb_reg};
            DSA_OFF_BCNT: rdata_next = {16'h0000, bcnt_reg};
            DSA_OFF_STAT: rdata_next = {27'h0000000, inblk_reg, pend_reg,
                                        breq_reg, state_reg};
            default:      rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ctrl_reg      <= dsa_ctrl_type'(DSA_CTRL_RST);
         mar_reg       <= DSA_ADDR_RST;
         mar_base_reg  <= DSA_ADDR_RST;
         marb_reg      <= DSA_ADDR_RST;
         marb_base_reg <= DSA_ADDR_RST;
         io_address_reg_reg      <= DSA_CNT_RST;
         tcnt_reg      <= DSA_CNT_RST;
         bcnt_reg      <= DSA_CNT_RST;
         pend_reg      <= 1'b0;
         inblk_reg     <= 1'b0;
         state_reg     <= ST_IDLE;
         xfer_reg      <= '0;
         xreq_reg      <= 1'b0;
         breq_reg      <= 1'b0;
         irq_reg       <= 1'b0;
         rdata_reg     <= 32'h00000000;
      end else begin
         ctrl_reg      <= ctrl_next;
         mar_reg       <= mar_next;
         mar_base_reg  <= mar_base_next;
         marb_reg      <= marb_next;
         marb_base_reg <= marb_base_next;
         io_address_reg_reg      <= io_address_reg_next;
         tcnt_reg      <= tcnt_next;
         bcnt_reg      <= bcnt_next;
         pend_reg      <= pend_next;
         inblk_reg     <= inblk_next;
         state_reg     <= state_next;
         xfer_reg      <= xfer_next;
         xreq_reg      <= xreq_next;
         breq_reg      <= breq_next;
         irq_reg       <= irq_next;
         rdata_reg     <= rdata_next;
      end
   end

   assign o_hreadyout = hreadyout_w;
   assign o_hresp     = hresp_w;
   assign o_hrdata    = rdata_reg;
   assign o_xfer      = xfer_reg;
   assign o_xfer_req  = xreq_reg;
   assign o_bus_req   = breq_reg;
   assign o_end_irq   = irq_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   logic done_now;
   assign done_now = (state_reg == ST_XFER) & i_xfer_done & ~acc.wr_en;

   seq_step_a: assert property (done_now && m_seq |=>
      mar_reg == dsa_step($past(mar_reg), $past(ctrl_reg.word), $past(ctrl_reg.dec)))
      else $error("sequential address step wrong");

   idle_hold_a: assert property (done_now && m_idle |=> $stable(mar_reg))
      else $error("idle mode address moved");

   io_high_a: assert property (o_xfer_req && !o_xfer.single && !ctrl_reg.fae
      |-> (ctrl_reg.dir ? o_xfer.src[23:16] : o_xfer.dst[23:16]) == DSA_IO_HIGH)
      else $error("io address upper byte not all ones");

   cnt_dec_a: assert property (done_now && !ctrl_reg.fae && !ctrl_reg.repeat_enable_bit
      |=> tcnt_reg == $past(tcnt_reg) - DSA_CNT_ONE)
      else $error("counter did not decrement");

   end_clr_a: assert property (done_now && m_seq && last |=> !ctrl_reg.channel_transfer_enable)
      else $error("enable not cleared at count end");

   end_irq_a: assert property (done_now && m_seq && last && ctrl_reg.transfer_end_irq_enable
      |=> o_end_irq ##1 !o_end_irq)
      else $error("end interrupt missing or too long");

   zero_max_a: assert property (done_now && m_seq && tcnt_reg == 16'h0000
      |=> ctrl_reg.channel_transfer_enable && tcnt_reg == 16'hffff)
      else $error("zero count ended early");

   rpt_noirq_a: assert property (done_now && m_rpt |=> !o_end_irq && ctrl_reg.channel_transfer_enable)
      else $error("repeat mode stopped or raised interrupt");

   rpt_load_a: assert property (done_now && m_rpt && wrap
      |=> mar_reg == $past(mar_base_reg) && tcnt_reg[7:0] == $past(tcnt_reg[15:8]))
      else $error("repeat reload wrong");

   steal_rel_a: assert property (done_now && !(is_auto && ctrl_reg.burst)
      |=> !o_bus_req)
      else $error("bus kept in cycle steal");

   burst_hold_a: assert property (done_now && is_auto && ctrl_reg.burst && !last
      |=> o_bus_req ##1 o_bus_req)
      else $error("bus released during burst");

   single_a_a: assert property (!IS_CHAN_B |-> !ctrl_reg.single)
      else $error("single address on channel A");

   seq_c: cover property (done_now && m_seq && last);
   idle_c: cover property (done_now && m_idle);
   rpt_c: cover property (done_now && m_rpt && wrap);
   burst_c: cover property ((o_bus_req && is_auto && ctrl_reg.burst) [*3]);

endmodule

// *** dsa_pkg.sv ***
package dsa_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] DSA_OFF_CTRL = 8'h00;
   localparam logic [7:0] DSA_OFF_MAR  = 8'h04;
   localparam logic [7:0] DSA_OFF_IO_ADDRESS_REG = 8'h08;
   localparam logic [7:0] DSA_OFF_TCNT = 8'h0c;
   localparam logic [7:0] DSA_OFF_MARB = 8'h10;
   localparam logic [7:0] DSA_OFF_BCNT = 8'h14;
   localparam logic [7:0] DSA_OFF_STAT = 8'h18;

   // ----------------------------------------------------------------
   // Reset values and fixed values
   // ----------------------------------------------------------------
   localparam logic [15:0] DSA_CTRL_RST = 16'h0000;
   localparam logic [23:0] DSA_ADDR_RST = 24'h000000;
   localparam logic [15:0] DSA_CNT_RST  = 16'h0000;
   localparam logic [7:0]  DSA_IO_HIGH  = 8'hff;
   localparam logic [23:0] DSA_STEP_B   = 24'h000001;
   localparam logic [23:0] DSA_STEP_W   = 24'h000002;
   localparam logic [15:0] DSA_CNT_ONE  = 16'h0001;
   localparam logic [7:0]  DSA_LOW_ONE  = 8'h01;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_TMR0 = 3'b000,
      SRC_TMR1 = 3'b001,
      SRC_TMR2 = 3'b010,
      SRC_TXC  = 3'b011,
      SRC_RXC  = 3'b100,
      SRC_EXT  = 3'b101,
      SRC_AUTO = 3'b110,
      SRC_NONE = 3'b111
   } dsa_src_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01
   } dsa_state_type;

   typedef struct packed {
      logic        blk_dst;
      logic        marb_fix;
      logic        marb_dec;
      logic        single;
      dsa_src_type src;
      logic        burst;
      logic        blke;
      logic        fae;
      logic        dec;
      logic        word;
      logic        dir;
      logic        repeat_enable_bit;
      logic        transfer_end_irq_enable;
      logic        channel_transfer_enable;
   } dsa_ctrl_type;

   typedef struct packed {
      logic [23:0] src;
      logic [23:0] dst;
      logic        word;
      logic        single;
   } dsa_xfer_type;

   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
   } dsa_acc_type;

   // ----------------------------------------------------------------
   // Address step by one byte or one word
   // ----------------------------------------------------------------
   function automatic logic [23:0] dsa_step(input logic [23:0] a, input logic word,
                                            input logic dec);
      logic [23:0] d;
      d = word ? DSA_STEP_W : DSA_STEP_B;
      return dec ? a - d : a + d;
   endfunction

endpackage

// *** dsa_ahb_regif.sv ***
module dsa_ahb_regif
   import dsa_pkg::*;
(
   input  wire logic        i_sys_clk,   // System clock
   input  wire logic        i_rstn,      // Synchronous reset, active low
   input  wire logic        i_hsel,      // Slave select
   input  wire logic [31:0] i_haddr,     // Address
   input  wire logic [1:0]  i_htrans,    // Transfer type
   input  wire logic        i_hwrite,    // Write not read
   input  wire logic        i_hready,    // Bus ready
   output logic             o_hreadyout, // Slave ready
   output logic             o_hresp,     // Response, always OKAY
   output logic             o_rd_take,   // Read address phase taken now
   output dsa_acc_type      o_acc        // Write data phase strobe and offset
);

   logic        take;
   dsa_acc_type acc_reg;
   dsa_acc_type acc_next;
   logic        rdy_reg;

   // ----------------------------------------------------------------
   // Address phase capture
   // ----------------------------------------------------------------
   always_comb begin
      take           = i_hsel & i_hready & i_htrans[1];
      acc_next.wr_en = take & i_hwrite;
      acc_next.addr  = take ? i_haddr[7:0] : acc_reg.addr;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         acc_reg <= '0;
         rdy_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         rdy_reg <= 1'b1;
      end
   end

   assign o_rd_take   = take & ~i_hwrite;
   assign o_acc       = acc_reg;
   assign o_hreadyout = rdy_reg;
   assign o_hresp     = 1'b0;

endmodule

// *** dsa_req_sel.sv ***
module dsa_req_sel
   import dsa_pkg::*;
#(
   parameter bit IS_CHAN_B = 1'b1
) (
   input  wire logic        i_sys_clk,  // System clock
   input  wire logic        i_rstn,     // Synchronous reset, active low
   input  wire logic [2:0]  i_tmr_req,  // Timer 0..2 compare/capture A
   input  wire logic        i_txc_req,  // Serial transmit complete
   input  wire logic        i_rxc_req,  // Serial receive complete
   input  wire logic        i_ext_req,  // External request
   input  dsa_src_type      i_src,      // Selected source
   output logic             o_trig      // One-cycle activation pulse
);

   logic lvl;
   logic prev_reg;

   always_comb begin
      case (i_src)
         SRC_TMR0: lvl = i_tmr_req[0];
         SRC_TMR1: lvl = i_tmr_req[1];
         SRC_TMR2: lvl = i_tmr_req[2];
         SRC_TXC:  lvl = i_txc_req;
         SRC_RXC:  lvl = i_rxc_req;
         SRC_EXT:  lvl = IS_CHAN_B & i_ext_req;
         default:  lvl = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= lvl;
      end
   end

   assign o_trig = lvl & ~prev_reg;

endmodule

// *** dsa_mem_model.sv ***
module dsa_mem_model (
   input  wire logic       i_sys_clk,  // System clock
   input  wire logic       i_rstn,     // Reset, active low
   input  wire logic       i_xfer_req, // Move requested
   input  wire logic [3:0] i_lat,      // Wait cycles before done
   output logic            o_done      // One-cycle done pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // ------------------------------------------------
   // One done pulse per move, prompt or slow
   // ------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (!i_rstn || !i_xfer_req || o_done) begin
         cnt    <= 4'h0;
         o_done <= 1'b0;
      end else if (cnt == i_lat) begin
         o_done <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// *** tb_dsa_channel.sv ***
module tb_dsa_channel
   import dsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [23:0] memory_address_reg;
      logic [15:0] io_address_reg;
      logic [15:0] cnt;
   } dsa_row_type;
   logic         clk = 0, rstn = 0, hsel = 0, hwrite = 0, txc = 0, rxc = 0, ext = 0;
   logic [31:0]  haddr = 0, hwdata = 0, hrdata, hrdata_a, d;
   logic [1:0]   htrans = 0;
   logic [2:0]   tmr = 0;
   logic [3:0]   lat = 0;
   logic [23:0]  a, st, io;
   logic         hrdyo, xreq, done, irq, breq, hresp, xreq_a, done_a;
   dsa_xfer_type xfer;
   dsa_row_type  r;
   int           err_total = 0, compares = 0, nirq = 0, n0;
   dsa_row_type  rows [6] = '{
      '{16'h0003, 24'hfffffe, 16'h1234, 16'h0003}, '{16'h0239, 24'h000001, 16'h00ff, 16'h0002},
      '{16'h0417, 24'h123456, 16'habcd, 16'h0002}, '{16'h0629, 24'h000010, 16'h0000, 16'h0001},
      '{16'h0807, 24'h00ff00, 16'hffff, 16'h0002}, '{16'h0a11, 24'h7ffffe, 16'h8000, 16'h0002}};

   dsa_channel dut (.i_sys_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
      .i_hready(hrdyo), .o_hreadyout(hrdyo), .o_hresp(hresp), .o_hrdata(hrdata), .i_tmr_req(tmr),
      .i_txc_req(txc), .i_rxc_req(rxc), .i_ext_req(ext), .o_xfer(xfer), .o_xfer_req(xreq),
      .i_xfer_done(done), .o_bus_req(breq), .o_end_irq(irq));
   dsa_mem_model mem (.i_sys_clk(clk), .i_rstn(rstn), .i_xfer_req(xreq), .i_lat(lat),
      .o_done(done));
   // Channel A twin on the same bus: external request and single address stay inert
   dsa_channel #(.IS_CHAN_B(1'b0)) dut_a (.i_sys_clk(clk), .i_rstn(rstn), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
      .i_hwdata(hwdata), .i_hready(hrdyo), .o_hreadyout(), .o_hresp(), .o_hrdata(hrdata_a),
      .i_tmr_req(tmr), .i_txc_req(txc), .i_rxc_req(rxc), .i_ext_req(ext), .o_xfer(),
      .o_xfer_req(xreq_a), .i_xfer_done(done_a), .o_bus_req(), .o_end_irq());
   dsa_mem_model mem_a (.i_sys_clk(clk), .i_rstn(rstn), .i_xfer_req(xreq_a), .i_lat(lat),
      .o_done(done_a));

   always #10 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) nirq <= nirq + 1;

   // ------------------------------------------------
   // Bus cycles, triggers and compares
   // ------------------------------------------------
   task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rv);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, ad};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hrdyo !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hrdyo !== 1'b1);
      rv = hrdata;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task trig(input logic [2:0] s);
      @(posedge clk);
      {ext, rxc, txc, tmr} <= 6'h1 << s;
      @(posedge clk);
      {ext, rxc, txc, tmr} <= 6'h0;
   endtask
   task hold(input logic lv);
      int t;
      t = 0;
      while (xreq !== lv && t < 50) begin
         @(posedge clk);
         #1;
         t++;
      end
      chk(xreq, lv);
   endtask
   task results;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      #(20 * 40000);
      err_total++;
      results();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk({hrdyo, hresp, xreq, irq, breq, xreq_a}, 6'h20);
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         a = r.memory_address_reg;
         n0 = nirq;
         st = r.ctrl[4] ? 24'h000002 : 24'h000001;
         io = {8'hff, r.io_address_reg};
         lat <= i[0] ? 4'h3 : 4'h0;
         ahb(1'b1, DSA_OFF_MAR, {8'h0, r.memory_address_reg}, d);
         ahb(1'b1, DSA_OFF_IO_ADDRESS_REG, {16'h0, r.io_address_reg}, d);
         ahb(1'b1, DSA_OFF_TCNT, {16'h0, r.cnt}, d);
         ahb(1'b1, DSA_OFF_CTRL, {16'h0, r.ctrl}, d);
         for (int k = 0; k < r.cnt; k++) begin
            trig(r.ctrl[11:9]);
            hold(1'b1);
            chk(breq, 1'b1);
            chk(xreq_a, r.ctrl[11:9] != 3'h5);
            chk(xfer.word, r.ctrl[4]);
            chk(xfer.src, r.ctrl[3] ? io : a);
            chk(xfer.dst, r.ctrl[3] ? a : io);
            hold(1'b0);
            chk(breq, 1'b0);
            if (!(r.ctrl[2] && r.ctrl[1])) a = r.ctrl[5] ? a - st : a + st;
         end
         repeat (3) @(posedge clk);
         ahb(1'b0, DSA_OFF_CTRL, 32'h0, d);
         chk(d[0], 1'b0);
         ahb(1'b0, DSA_OFF_TCNT, 32'h0, d);
         chk(d, 32'h0);
         ahb(1'b0, DSA_OFF_MAR, 32'h0, d);
         chk(d, {8'h0, a});
         chk(nirq - n0, r.ctrl[1]);
         $display("row %0d done", i);
      end
      ahb(1'b1, DSA_OFF_TCNT, 32'h0, d);
      ahb(1'b1, DSA_OFF_CTRL, 32'h1, d);
      trig(3'h0);
      hold(1'b1);
      hold(1'b0);
      ahb(1'b0, DSA_OFF_TCNT, 32'h0, d);
      chk(d, 32'h0000ffff);
      ahb(1'b0, DSA_OFF_CTRL, 32'h0, d);
      chk(d[0], 1'b1);
      n0 = nirq;
      ahb(1'b1, DSA_OFF_MAR, 32'h00000100, d);
      ahb(1'b1, DSA_OFF_TCNT, 32'h00000202, d);
      ahb(1'b1, DSA_OFF_CTRL, 32'h00000005, d);
      for (int k = 0; k < 2; k++) begin
         trig(3'h0);
         hold(1'b1);
         hold(1'b0);
      end
      ahb(1'b0, DSA_OFF_TCNT, 32'h0, d);
      chk(d, 32'h00000202);
      ahb(1'b0, DSA_OFF_MAR, 32'h0, d);
      chk(d, 32'h00000100);
      ahb(1'b0, DSA_OFF_CTRL, 32'h0, d);
      chk({d[0], nirq - n0 == 0}, 2'b11);
      $display("repeat test done");
      ahb(1'b1, DSA_OFF_MAR, 32'h00200000, d);
      ahb(1'b1, DSA_OFF_MARB, 32'h00300000, d);
      ahb(1'b1, DSA_OFF_TCNT, 32'h00000003, d);
      ahb(1'b1, DSA_OFF_CTRL, 32'h00001d41, d);
      repeat (6) @(posedge clk);
      #1;
      chk(breq, 1'b1);
      repeat (20) @(posedge clk);
      #1;
      chk({breq, xreq}, 2'b00);
      ahb(1'b0, DSA_OFF_MAR, 32'h0, d);
      chk(d, 32'h00200003);
      ahb(1'b0, DSA_OFF_MARB, 32'h0, d);
      chk(d, 32'h00300003);
      ahb(1'b0, DSA_OFF_CTRL, 32'h0, d);
      chk(d, 32'h00001d40);
      chk(hrdata_a, 32'h00000d40);
      $display("burst test done");
      ahb(1'b1, DSA_OFF_CTRL, 32'h0, d);
      trig(3'h0);
      repeat (10) @(posedge clk);
      chk(xreq, 1'b0);
      ahb(1'b0, 8'h40, 32'h0, d);
      chk(d, 32'h0);
      $display("hand tests done");
      results();
   end
endmodule
